/* hdl/spr_responder.sv */
`timescale 1ns/1ps
// ==========================================================================
module spr_responder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Command from the initiator side
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_protocol_i,
  input wire logic [15:0] cmd_specific_i,
  input wire logic [31:0] cmd_alloc_i,
  output logic cmd_ready_o,
  // Completion status
  output logic done_o,
  output logic invalid_field_o,
  // Parameter data stream
  output logic dat_valid_o,
  output logic [7:0] dat_byte_o,
  output logic dat_last_o,
  input wire logic dat_ready_i,
  // Content load port
  input wire logic ld_cert_we_i,
  input wire logic ld_compl_we_i,
  input wire logic [spr_pkg::CERT_AW-1:0] ld_addr_i,
  input wire logic [7:0] ld_data_i,
  input wire logic [spr_pkg::CERT_AW:0] cert_len_i,
  input wire logic [spr_pkg::COMPL_AW:0] compl_len_i,
  input wire logic compl_supported_i
);
  import spr_pkg::*;

  // ==========================================================================
  // Helpers

  // Byte k of a big-endian length field n bytes wide
  // Most significant byte leaves first; a zero shift gives the low byte
  function automatic logic [7:0] field_byte(input logic [31:0] v, input logic [31:0] k, input logic [31:0] n);
    logic [31:0] sh;
    // Wanted byte shifted down to bits 7:0
    sh = v >> (32'd8 * (n - 32'd1 - k));
    return sh[7:0];
  endfunction : field_byte

  // Format selected by the protocol-specific code
  // Reserved codes fall back to the list layout; cmd_ok keeps them from being served
  function automatic spr_fmt_e decode_fmt(input logic [15:0] spec);
    spr_fmt_e f;
    case (spec)
      SPEC_CERT: f = FMT_CERT;
      SPEC_COMPL: f = FMT_COMPL;
      default: f = FMT_LIST;
    endcase
    return f;
  endfunction : decode_fmt

  // ==========================================================================
  // State
  // Command context latched at accept: format, allocation and payload length
  spr_state_e state_r;
  spr_fmt_e fmt_r;
  logic [31:0] alloc_r;
  logic [31:0] len_r;
  logic [31:0] idx_r;
  logic cmd_ready_r;
  logic done_r;
  logic invalid_r;
  logic dat_valid_r;
  logic [7:0] dat_byte_r;
  logic dat_last_r;

  // Content arrays written by the load port
  // Payload offsets wrap at the array size, so a longer length repeats bytes
  // No reset on the arrays: content survives a reset, only the load port changes it
  logic [7:0] cert_mem [0:(1<<CERT_AW)-1];
  logic [7:0] compl_mem [0:(1<<COMPL_AW)-1];

  // Decode of the offered command
  logic cmd_take;
  logic cmd_ok;
  spr_fmt_e cmd_fmt;
  logic [31:0] cmd_len;
  logic adv;

  // Request kinds and the end of a stream, each decoded once
  logic cmd_go;
  logic cmd_nil;
  logic end_take;

  // Byte builder inputs and result
  spr_fmt_e pick_fmt;
  logic [31:0] pick_len;
  logic [31:0] pick_idx;
  logic [31:0] hdr;
  logic [31:0] lpos;
  logic [31:0] lbytes;
  logic [31:0] off;
  logic [23:0] list_sh;
  logic [7:0] byte_nxt;

  // ==========================================================================
  // Command acceptance and code check
  // Code check on the live inputs; nothing from earlier commands is kept
  assign cmd_take = cmd_valid_i && cmd_ready_r;
  assign adv = dat_valid_r && dat_ready_i;

  // Good request with bytes to send: streams exactly the allocation length
  assign cmd_go = cmd_take && cmd_ok && (cmd_alloc_i != 32'h0000_0000);
  // Good request with a zero allocation: answered by a done pulse alone
  assign cmd_nil = cmd_take && cmd_ok && (cmd_alloc_i == 32'h0000_0000);
  // Final byte taken by the sink: stream over, ready comes back
  assign end_take = adv && dat_last_r;

  always_comb begin
    cmd_fmt = decode_fmt(cmd_specific_i);
    // Only protocol 00h with a defined code is answered here
    // Other protocols and reserved codes are turned away as an invalid field
    cmd_ok = (cmd_protocol_i == PROTO_INFO) &&
      ((cmd_specific_i == SPEC_LIST) || (cmd_specific_i == SPEC_CERT) ||
       ((cmd_specific_i == SPEC_COMPL) && compl_supported_i));
    // Payload length behind the header, taken at accept
    case (cmd_fmt)
      FMT_CERT: cmd_len = 32'(cert_len_i);
      FMT_COMPL: cmd_len = 32'(compl_len_i);
      default: cmd_len = PROTO_COUNT;
    endcase
  end

  // ==========================================================================
  // Byte builder: header, payload, then pad
  // Idle: byte 0 of the offered command, ready at the accepting edge
  // Sending: the byte after the one on the output
  // Latched lengths while sending, so later changes on the length inputs
  // cannot bend a stream already under way
  always_comb begin
    if (state_r == ST_IDLE) begin
      pick_fmt = cmd_fmt;
      pick_len = cmd_len;
      pick_idx = 32'h0000_0000;
    end else begin
      pick_fmt = fmt_r;
      pick_len = len_r;
      pick_idx = idx_r + 32'h0000_0001;
    end
    case (pick_fmt)
      FMT_CERT: begin
        hdr = CERT_HDR;
        lpos = CERT_LEN_POS;
        lbytes = CERT_LEN_BYTES;
      end
      FMT_COMPL: begin
        hdr = COMPL_HDR;
        lpos = COMPL_LEN_POS;
        lbytes = COMPL_LEN_BYTES;
      end
      default: begin
        hdr = LIST_HDR;
        lpos = LIST_LEN_POS;
        lbytes = LIST_LEN_BYTES;
      end
    endcase
    // Payload offset, only used once the index is past the header
    off = pick_idx - hdr;
    list_sh = PROTO_LIST >> (32'd8 * off);
    // Zero bytes before the length field, then the field, payload and pad
    if (pick_idx < lpos) begin
      byte_nxt = ZERO_BYTE;
    end else if (pick_idx < hdr) begin
      byte_nxt = field_byte(pick_len, pick_idx - lpos, lbytes);
    end else if (pick_idx < hdr + pick_len) begin
      case (pick_fmt)
        FMT_CERT: byte_nxt = cert_mem[off[CERT_AW-1:0]];
        FMT_COMPL: byte_nxt = compl_mem[off[COMPL_AW-1:0]];
        default: byte_nxt = list_sh[7:0];
      endcase
    end else begin
      byte_nxt = ZERO_BYTE;
    end
  end

  // ==========================================================================
  // Content load writes
  // A write during a transfer changes only bytes not yet built;
  // no handshake on this port, so it is meant for use between requests
  always_ff @(posedge clk_i) begin
    if (ld_cert_we_i) begin
      cert_mem[ld_addr_i] <= ld_data_i;
    end
    if (ld_compl_we_i) begin
      compl_mem[ld_addr_i[COMPL_AW-1:0]] <= ld_data_i;
    end
  end

  // ==========================================================================
  // Sequencer: state, command context and byte index
  // One request at a time: a new command is taken only back in idle,
  // after the sink has taken the last byte of the previous stream
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      fmt_r <= FMT_LIST;
      alloc_r <= 32'h0000_0000;
      len_r <= 32'h0000_0000;
      idx_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Context latched fresh on each request, no out-command history kept
          if (cmd_go) begin
            state_r <= ST_SEND;
            fmt_r <= cmd_fmt;
            alloc_r <= cmd_alloc_i;
            len_r <= cmd_len;
            idx_r <= 32'h0000_0000;
          end
        end
        ST_SEND: begin
          // idx_r names the byte on the output; it moves only when that byte is taken
          if (adv) begin
            if (dat_last_r) begin
              state_r <= ST_IDLE;
            end else begin
              idx_r <= idx_r + 32'h0000_0001;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Command ready: high only while idle
  // Rejected and zero-allocation commands leave it high,
  // so the next command may follow on the very next edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_ready_r <= 1'b1;
    end else if (cmd_go) begin
      cmd_ready_r <= 1'b0;
    end else if (end_take) begin
      cmd_ready_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Status pulses
  // One cycle each; a rejected command sends no byte and never raises done
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      done_r <= 1'b0;
      invalid_r <= 1'b0;
    end else begin
      invalid_r <= cmd_take && !cmd_ok;
      done_r <= cmd_nil || end_take;
    end
  end

  // ==========================================================================
  // Output byte register, stream stops at the allocation length
  // Last flag worked out one byte ahead, so it stands with the byte it marks;
  // longer data is cut at the allocation, shorter data padded up to it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dat_valid_r <= 1'b0;
      dat_byte_r <= ZERO_BYTE;
      dat_last_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      if (cmd_go) begin
        dat_valid_r <= 1'b1;
        dat_byte_r <= byte_nxt;
        dat_last_r <= (cmd_alloc_i == 32'h0000_0001);
      end
    end else if (adv) begin
      if (dat_last_r) begin
        // Stream over: valid drops and the byte bus returns to zero
        dat_valid_r <= 1'b0;
        dat_byte_r <= ZERO_BYTE;
        dat_last_r <= 1'b0;
      end else begin
        dat_byte_r <= byte_nxt;
        dat_last_r <= (idx_r + 32'h0000_0002 == alloc_r);
      end
    end
  end

  // Outputs straight from flops
  // Every output is a register, so the far side sees no decode glitches
  assign cmd_ready_o = cmd_ready_r;
  assign done_o = done_r;
  assign invalid_field_o = invalid_r;
  assign dat_valid_o = dat_valid_r;
  assign dat_byte_o = dat_byte_r;
  assign dat_last_o = dat_last_r;

endmodule : spr_responder

/* hdl/spr_pkg.sv */
package spr_pkg;

  // ==========================================================================
  // Command decode values
  localparam logic [7:0] PROTO_INFO = 8'h00;
  localparam logic [15:0] SPEC_LIST = 16'h0000;
  localparam logic [15:0] SPEC_CERT = 16'h0001;
  localparam logic [15:0] SPEC_COMPL = 16'h0002;

  // ==========================================================================
  // Parameter data layouts: header size, length field start, length field bytes
  localparam logic [31:0] LIST_HDR = 32'h0000_0008;
  localparam logic [31:0] LIST_LEN_POS = 32'h0000_0006;
  localparam logic [31:0] LIST_LEN_BYTES = 32'h0000_0002;
  localparam logic [31:0] CERT_HDR = 32'h0000_0004;
  localparam logic [31:0] CERT_LEN_POS = 32'h0000_0002;
  localparam logic [31:0] CERT_LEN_BYTES = 32'h0000_0002;
  localparam logic [31:0] COMPL_HDR = 32'h0000_0004;
  localparam logic [31:0] COMPL_LEN_POS = 32'h0000_0000;
  localparam logic [31:0] COMPL_LEN_BYTES = 32'h0000_0004;

  // Value of reserved header bytes and of pad bytes
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================================
  // Supported protocol list, ascending, entry 0 in the low byte
  localparam logic [31:0] PROTO_COUNT = 32'h0000_0003;
  localparam logic [23:0] PROTO_LIST = 24'h02_0100;

  // ==========================================================================
  // Content store sizes (address widths of the byte arrays)
  localparam int CERT_AW = 10;
  localparam int COMPL_AW = 10;

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {ST_IDLE, ST_SEND} spr_state_e;
  typedef enum logic [1:0] {FMT_LIST, FMT_CERT, FMT_COMPL} spr_fmt_e;

endpackage : spr_pkg

/* bench/spr_responder_sva.sv */
`timescale 1ns/1ps
// ==========
// Response checker
module spr_responder_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Command side
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_protocol_i,
  input wire logic [15:0] cmd_specific_i,
  input wire logic [31:0] cmd_alloc_i,
  input wire logic compl_supported_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire logic invalid_field_o,
  // Data side
  input wire logic dat_valid_o,
  input wire logic [7:0] dat_byte_o,
  input wire logic dat_last_o,
  input wire logic dat_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Steps of a request
  sequence acc; cmd_valid_i && cmd_ready_o && cmd_protocol_i == 8'h00; endsequence
  sequence take; dat_valid_o && dat_ready_i; endsequence
  stall_hold_a: assert property (dat_valid_o && !dat_ready_i
    |=> dat_valid_o && $stable(dat_byte_o) && $stable(dat_last_o))
    else $error("byte changed while stalled");
  busy_ready_a: assert property (dat_valid_o |-> !cmd_ready_o)
    else $error("ready during stream");
  resv_code_a: assert property (acc ##0 cmd_specific_i > 16'h0002 |=> invalid_field_o && !dat_valid_o)
    else $error("reserved code not refused");
  compl_off_a: assert property (acc ##0 cmd_specific_i == 16'h0002 && !compl_supported_i |=> invalid_field_o)
    else $error("optional code not refused");
  list_start_a: assert property (acc ##0 cmd_specific_i == 16'h0000 && cmd_alloc_i != 0
    |=> dat_valid_o && dat_byte_o == 8'h00 && !invalid_field_o)
    else $error("list start wrong");
  cert_start_a: assert property (acc ##0 cmd_specific_i == 16'h0001 && cmd_alloc_i != 0
    |=> dat_valid_o && dat_byte_o == 8'h00)
    else $error("certificate start wrong");
  compl_start_a: assert property (acc ##0 cmd_specific_i == 16'h0002 && compl_supported_i
    && cmd_alloc_i != 0 |=> dat_valid_o && dat_byte_o == 8'h00 && !invalid_field_o)
    else $error("compliance start wrong");
  proto_other_a: assert property (cmd_valid_i && cmd_ready_o && cmd_protocol_i != 8'h00
    |=> invalid_field_o && !dat_valid_o && !done_o)
    else $error("other protocol not refused");
  zero_alloc_a: assert property (acc ##0 cmd_specific_i < 16'h0002 && cmd_alloc_i == 0
    |=> done_o && !dat_valid_o)
    else $error("empty request not done");
  last_done_a: assert property (take ##0 dat_last_o |=> done_o && cmd_ready_o && !dat_valid_o)
    else $error("no done after last byte");
endmodule : spr_responder_sva
bind spr_responder spr_responder_sva i_sva (.clk_i, .reset_i, .cmd_valid_i, .cmd_protocol_i, .cmd_specific_i,
  .cmd_alloc_i, .compl_supported_i, .cmd_ready_o, .done_o, .invalid_field_o, .dat_valid_o, .dat_byte_o,
  .dat_last_o, .dat_ready_i);

/* bench/spr_host_model.sv */
`timescale 1ns/1ps
// ==========
// Initiator-side data sink
module spr_host_model (
  // Clock and stall mode
  input wire logic clk_i,
  input wire logic slow_i,
  // Sink ready
  output logic dat_ready_o
);
  logic [1:0] ph_r = 2'h0;
  // Stall phase, one of three cycles ready when slow
  always @(negedge clk_i) begin
    ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
  end
  // Takes any byte count, so a stream of any allocation length passes
  assign dat_ready_o = !slow_i || ph_r == 2'h0;
endmodule : spr_host_model

/* bench/tb_spr_responder.sv */
`timescale 1ns/1ps
// ==========
// Responder bench
module tb_spr_responder;
  import spr_pkg::*;
  // Row: command and options, then the expected refusal
  typedef struct {logic [7:0] pr; logic [15:0] sp; logic [7:0] al; logic [7:0] cl; logic sup; logic slow;
    logic inv;} spr_row_s;
  logic clk_i = 0, reset_i = 1, cmd_valid_i = 0, ld_we = 0, slow = 0, sup = 0;
  logic [7:0] cmd_protocol_i = 0, ld_data_i = 0, cl = 0;
  logic [15:0] cmd_specific_i = 0;
  logic [31:0] cmd_alloc_i = 0;
  logic [9:0] ld_addr_i = 0;
  logic cmd_ready_o, done_o, invalid_field_o, dat_valid_o, dat_last_o, dat_ready;
  logic [7:0] dat_byte_o;
  int bad_count = 0, cmp_count = 0, idx = 0;
  spr_row_s r;
  spr_row_s rows[11] = '{
    '{8'h00, 16'h0000, 8'h0c, 8'h00, 1'b1, 1'b0, 1'b0}, '{8'h00, 16'h0000, 8'h0c, 8'h00, 1'b1, 1'b1, 1'b0},
    '{8'h00, 16'h0000, 8'h05, 8'h00, 1'b1, 1'b0, 1'b0}, '{8'h00, 16'h0001, 8'h09, 8'h03, 1'b1, 1'b1, 1'b0},
    '{8'h00, 16'h0001, 8'h06, 8'h00, 1'b1, 1'b0, 1'b0}, '{8'h00, 16'h0002, 8'h0c, 8'h05, 1'b1, 1'b1, 1'b0},
    '{8'h00, 16'h0002, 8'h08, 8'h05, 1'b0, 1'b0, 1'b1}, '{8'h00, 16'h0003, 8'h08, 8'h00, 1'b1, 1'b0, 1'b1},
    '{8'h00, 16'hffff, 8'h08, 8'h00, 1'b1, 1'b0, 1'b1}, '{8'h01, 16'h0000, 8'h08, 8'h00, 1'b1, 1'b0, 1'b1},
    '{8'h00, 16'h0001, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0}};
  spr_responder i_dut (.clk_i, .reset_i, .cmd_valid_i, .cmd_protocol_i, .cmd_specific_i, .cmd_alloc_i,
    .cmd_ready_o, .done_o, .invalid_field_o, .dat_valid_o, .dat_byte_o, .dat_last_o, .dat_ready_i(dat_ready),
    .ld_cert_we_i(ld_we), .ld_compl_we_i(ld_we), .ld_addr_i, .ld_data_i, .cert_len_i({3'h0, cl}),
    .compl_len_i({3'h0, cl}), .compl_supported_i(sup));
  spr_host_model i_host (.clk_i, .slow_i(slow), .dat_ready_o(dat_ready));
  // Clock
  always #2 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_b(input int k);
    int h;
    int n;
    h = (r.sp == 0) ? 8 : 4;
    n = (r.sp == 0) ? 3 : int'(r.cl);
    if (k < h) return 8'(n >> (8 * (h - 1 - k)));
    if (k >= h + n) return 8'h00;
    return (r.sp == 0) ? 8'(k - h) : 8'(k - h) ^ 8'h5a;
  endfunction : exp_b
  // Every taken byte against the expected layout
  always @(posedge clk_i) begin
    if (!reset_i && dat_valid_o && dat_ready) begin
      chk(dat_byte_o, exp_b(idx));
      chk(dat_last_o, idx == r.al - 1);
      idx++;
    end
  end
  task automatic offer(input spr_row_s x);
    @(negedge clk_i);
    r = x;
    idx = 0;
    {cmd_protocol_i, cmd_specific_i, cmd_alloc_i} = {x.pr, x.sp, 24'h00_0000, x.al};
    {cl, sup, slow, cmd_valid_i} = {x.cl, x.sup, x.slow, 1'b1};
    @(negedge clk_i);
    cmd_valid_i = 0;
  endtask : offer
  task automatic run(input spr_row_s x);
    int w;
    offer(x);
    chk(invalid_field_o, x.inv);
    if (x.inv) chk(dat_valid_o, 0);
    else if (x.al == 0) chk(done_o, 1);
    else begin
      for (w = 0; w < 200 && done_o !== 1'b1; w++) @(negedge clk_i);
      chk(done_o, 1);
      chk(idx, x.al);
    end
    chk(cmd_ready_o, 1);
    $display("test end code=%h alloc=%0d", x.sp, x.al);
  endtask : run
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_i);
    reset_i = 0;
    chk(cmd_ready_o, 1);
    for (int a = 0; a < 16; a++) begin
      @(negedge clk_i);
      {ld_we, ld_addr_i, ld_data_i} = {1'b1, 10'(a), 8'(a) ^ 8'h5a};
    end
    @(negedge clk_i);
    ld_we = 0;
    foreach (rows[i]) run(rows[i]);
    // Reset in mid-stream, then the request again from byte zero
    offer(rows[1]);
    repeat (4) @(negedge clk_i);
    reset_i = 1;
    repeat (2) @(negedge clk_i);
    chk(dat_valid_o, 0);
    chk(cmd_ready_o, 1);
    chk(done_o, 0);
    reset_i = 0;
    run(rows[1]);
    end_of_test();
  end
endmodule : tb_spr_responder
